// ==== design/cpu_exec_core.sv ====
// execution core for increments, jumps, calls and byte loads
`include "cpu_exec_regs.svh"

module cpu_exec_core #(
  parameter logic [15:0] START_PC    = 16'h0000,
  parameter logic [15:0] START_SP    = 16'h00ff,
  parameter logic [7:0]  START_FLAGS = 8'h00
) (
  input  wire logic                ref_clk_in,
  input  wire logic                reset_n_in,
  input  wire logic [7:0]          data_in,
  output      cpu_exec_pkg::bus_t  bus_out,
  output      logic [7:0]          acc_a_out,
  output      logic [7:0]          acc_b_out,
  output      logic [15:0]         first_pointer_out,
  output      logic [15:0]         second_pointer_out,
  output      logic [15:0]         stack_pointer_out,
  output      logic [15:0]         program_counter_out,
  output      logic [7:0]          flag_register_out,
  output      logic                unknown_opcode_out
);
  import cpu_exec_pkg::*;

  // opcode classification; prefix only valid before pointer-relative forms and the pointer bump
  function automatic decode_t decode_op(input logic [7:0] op, input logic pre);
    decode_t d;
    d = '{cls: cls_unknown, mode: md_no_operand, acc_b: 1'b0};
    case (op)
      `OP_BUMP_ACC_A:   d = '{cls: cls_bump_acc, mode: md_no_operand, acc_b: 1'b0};
      `OP_BUMP_ACC_B:   d = '{cls: cls_bump_acc, mode: md_no_operand, acc_b: 1'b1};
      `OP_BUMP_MEM_EXT: d = '{cls: cls_bump_mem, mode: md_sixteen_bit, acc_b: 1'b0};
      `OP_BUMP_MEM_IDX: d = '{cls: cls_bump_mem, mode: md_offset_from_pointer, acc_b: 1'b0};
      `OP_SP_BUMP:      d = '{cls: cls_sp_bump, mode: md_no_operand, acc_b: 1'b0};
      `OP_PTR_BUMP:     d = '{cls: cls_ptr_bump, mode: md_no_operand, acc_b: 1'b0};
      `OP_JUMP_EXT:     d = '{cls: cls_jump, mode: md_sixteen_bit, acc_b: 1'b0};
      `OP_JUMP_IDX:     d = '{cls: cls_jump, mode: md_offset_from_pointer, acc_b: 1'b0};
      `OP_CALL_PAGE:    d = '{cls: cls_call, mode: md_page_zero, acc_b: 1'b0};
      `OP_CALL_EXT:     d = '{cls: cls_call, mode: md_sixteen_bit, acc_b: 1'b0};
      `OP_CALL_IDX:     d = '{cls: cls_call, mode: md_offset_from_pointer, acc_b: 1'b0};
      `OP_LOAD_A_IMM:   d = '{cls: cls_load, mode: md_immediate, acc_b: 1'b0};
      `OP_LOAD_A_PAGE:  d = '{cls: cls_load, mode: md_page_zero, acc_b: 1'b0};
      `OP_LOAD_A_EXT:   d = '{cls: cls_load, mode: md_sixteen_bit, acc_b: 1'b0};
      `OP_LOAD_A_IDX:   d = '{cls: cls_load, mode: md_offset_from_pointer, acc_b: 1'b0};
      `OP_LOAD_B_IMM:   d = '{cls: cls_load, mode: md_immediate, acc_b: 1'b1};
      `OP_LOAD_B_PAGE:  d = '{cls: cls_load, mode: md_page_zero, acc_b: 1'b1};
      `OP_LOAD_B_EXT:   d = '{cls: cls_load, mode: md_sixteen_bit, acc_b: 1'b1};
      `OP_LOAD_B_IDX:   d = '{cls: cls_load, mode: md_offset_from_pointer, acc_b: 1'b1};
      default:          d = '{cls: cls_unknown, mode: md_no_operand, acc_b: 1'b0};
    endcase
    if (pre && !(d.mode == md_offset_from_pointer || d.cls == cls_ptr_bump)) begin
      d = '{cls: cls_unknown, mode: md_no_operand, acc_b: 1'b0};
    end
    return d;
  endfunction : decode_op

  // bus word presented during a given state, from that state's register values
  function automatic bus_t bus_for(input exec_state_t st, input logic [15:0] pc,
                                   input logic [15:0] sp, input logic [15:0] ea,
                                   input logic [7:0] tmp);
    bus_t b;
    b = '{addr: pc, data: `BYTE_ZERO, rw: 1'b1};
    case (st)
      st_index_idle,
      st_modify_idle,
      st_pointer_idle: b = '{addr: `IDLE_ADDR, data: `BYTE_ZERO, rw: 1'b1};
      st_ea_read:      b = '{addr: ea, data: `BYTE_ZERO, rw: 1'b1};
      st_ea_write:     b = '{addr: ea, data: tmp, rw: 1'b0};
      st_stack_read:   b = '{addr: sp, data: `BYTE_ZERO, rw: 1'b1};
      st_push_lo:      b = '{addr: sp, data: pc[7:0], rw: 1'b0};
      st_push_hi:      b = '{addr: sp, data: pc[15:8], rw: 1'b0};
      default:         b = '{addr: pc, data: `BYTE_ZERO, rw: 1'b1};
    endcase
    return b;
  endfunction : bus_for

  exec_state_t  state_ff,   nxt_state;
  logic [15:0]  pc_ff,      nxt_pc;
  logic [15:0]  sp_ff,      nxt_sp;
  logic [15:0]  x_ff,       nxt_x;
  logic [15:0]  y_ff,       nxt_y;
  logic [7:0]   acc_a_ff,   nxt_acc_a;
  logic [7:0]   acc_b_ff,   nxt_acc_b;
  logic [7:0]   flags_ff,   nxt_flags;
  logic [7:0]   opcode_ff,  nxt_opcode;
  logic         prefix_ff,  nxt_prefix;
  logic [15:0]  ea_ff,      nxt_ea;
  logic [7:0]   tmp_ff,     nxt_tmp;
  bus_t         bus_ff,     nxt_bus;
  logic         unknown_ff, nxt_unknown;

  decode_t      dec;
  logic [15:0]  base_ptr;
  logic [15:0]  idx_ea;
  logic [15:0]  ptr_sum;
  logic         unit_bump;
  logic [7:0]   unit_operand;
  byte_result_t unit_res;

  assign dec      = decode_op(opcode_ff, prefix_ff);
  assign base_ptr = prefix_ff ? y_ff : x_ff;
  // offset is unsigned: zero-extended, never sign-extended
  assign idx_ea   = base_ptr + {`PAGE_ZERO_HI, tmp_ff};
  assign ptr_sum  = base_ptr + `WORD_ONE;

  // the unit sees the accumulator only in the inherent bump cycle
  assign unit_bump    = (dec.cls == cls_bump_acc) || (dec.cls == cls_bump_mem);
  assign unit_operand = (state_ff == st_operand1 && dec.cls == cls_bump_acc) ?
                        (dec.acc_b ? acc_b_ff : acc_a_ff) : data_in;

  byte_flag_unit u_flag_unit (
    .bump_in    (unit_bump),
    .operand_in (unit_operand),
    .result_out (unit_res)
  );

  always_comb begin
    nxt_state   = state_ff;
    nxt_pc      = pc_ff;
    nxt_sp      = sp_ff;
    nxt_x       = x_ff;
    nxt_y       = y_ff;
    nxt_acc_a   = acc_a_ff;
    nxt_acc_b   = acc_b_ff;
    nxt_flags   = flags_ff;
    nxt_opcode  = opcode_ff;
    nxt_prefix  = prefix_ff;
    nxt_ea      = ea_ff;
    nxt_tmp     = tmp_ff;
    nxt_unknown = 1'b0;

    case (state_ff)
      st_fetch: begin
        nxt_opcode = data_in;
        nxt_pc     = pc_ff + `WORD_ONE;
        if (data_in == `OP_PREFIX_Y && !prefix_ff) begin
          nxt_prefix = 1'b1;
        end else begin
          nxt_state = st_operand1;
        end
      end
      st_operand1: begin
        if (dec.mode == md_no_operand) begin
          // inherent forms read the next byte and throw it away
          case (dec.cls)
            cls_bump_acc: begin
              if (dec.acc_b) begin
                nxt_acc_b = unit_res.value;
              end else begin
                nxt_acc_a = unit_res.value;
              end
              nxt_flags[`FLAG_N] = unit_res.n;
              nxt_flags[`FLAG_Z] = unit_res.z;
              nxt_flags[`FLAG_V] = unit_res.v;
              nxt_state = st_fetch;
            end
            cls_sp_bump:  nxt_state = st_stack_read;
            cls_ptr_bump: nxt_state = st_pointer_idle;
            default: begin
              nxt_unknown = 1'b1;
              nxt_state   = st_fetch;
            end
          endcase
        end else begin
          nxt_pc = pc_ff + `WORD_ONE;
          case (dec.mode)
            md_immediate: begin
              if (dec.acc_b) begin
                nxt_acc_b = unit_res.value;
              end else begin
                nxt_acc_a = unit_res.value;
              end
              nxt_flags[`FLAG_N] = unit_res.n;
              nxt_flags[`FLAG_Z] = unit_res.z;
              nxt_flags[`FLAG_V] = unit_res.v;
              nxt_state = st_fetch;
            end
            md_page_zero: begin
              nxt_ea    = {`PAGE_ZERO_HI, data_in};
              nxt_state = st_ea_read;
            end
            md_sixteen_bit: begin
              nxt_ea    = {data_in, ea_ff[7:0]};
              nxt_state = st_operand2;
            end
            default: begin
              nxt_tmp   = data_in;
              nxt_state = st_index_idle;
            end
          endcase
        end
      end
      st_operand2: begin
        nxt_pc = pc_ff + `WORD_ONE;
        nxt_ea = {ea_ff[15:8], data_in};
        if (dec.cls == cls_jump) begin
          nxt_pc    = {ea_ff[15:8], data_in};
          nxt_state = st_fetch;
        end else begin
          nxt_state = st_ea_read;
        end
      end
      st_index_idle: begin
        nxt_ea = idx_ea;
        if (dec.cls == cls_jump) begin
          nxt_pc    = idx_ea;
          nxt_state = st_fetch;
        end else begin
          nxt_state = st_ea_read;
        end
      end
      st_ea_read: begin
        case (dec.cls)
          cls_load: begin
            if (dec.acc_b) begin
              nxt_acc_b = unit_res.value;
            end else begin
              nxt_acc_a = unit_res.value;
            end
            nxt_flags[`FLAG_N] = unit_res.n;
            nxt_flags[`FLAG_Z] = unit_res.z;
            nxt_flags[`FLAG_V] = unit_res.v;
            nxt_state = st_fetch;
          end
          cls_bump_mem: begin
            nxt_tmp            = unit_res.value;
            nxt_flags[`FLAG_N] = unit_res.n;
            nxt_flags[`FLAG_Z] = unit_res.z;
            nxt_flags[`FLAG_V] = unit_res.v;
            nxt_state          = st_modify_idle;
          end
          // call reads its target once and ignores the byte
          default: nxt_state = st_push_lo;
        endcase
      end
      st_modify_idle: nxt_state = st_ea_write;
      st_ea_write:    nxt_state = st_fetch;
      st_stack_read: begin
        nxt_sp    = sp_ff + `WORD_ONE;
        nxt_state = st_fetch;
      end
      st_pointer_idle: begin
        if (prefix_ff) begin
          nxt_y = ptr_sum;
        end else begin
          nxt_x = ptr_sum;
        end
        nxt_flags[`FLAG_Z] = (ptr_sum == `WORD_ZERO);
        nxt_state = st_fetch;
      end
      st_push_lo: begin
        // pc already points past the instruction: plus two or plus three
        nxt_sp    = sp_ff - `WORD_ONE;
        nxt_state = st_push_hi;
      end
      st_push_hi: begin
        nxt_sp    = sp_ff - `WORD_ONE;
        nxt_pc    = ea_ff;
        nxt_state = st_fetch;
      end
      default: nxt_state = st_fetch;
    endcase

    if (nxt_state == st_fetch && state_ff != st_fetch) begin
      nxt_prefix = 1'b0;
    end
    // bus is registered: the next state's word is prepared one cycle early
    nxt_bus = bus_for(nxt_state, nxt_pc, nxt_sp, nxt_ea, nxt_tmp);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state_ff   <= st_fetch;
      pc_ff      <= START_PC;
      sp_ff      <= START_SP;
      x_ff       <= `WORD_ZERO;
      y_ff       <= `WORD_ZERO;
      acc_a_ff   <= `BYTE_ZERO;
      acc_b_ff   <= `BYTE_ZERO;
      flags_ff   <= START_FLAGS;
      opcode_ff  <= `BYTE_ZERO;
      prefix_ff  <= 1'b0;
      ea_ff      <= `WORD_ZERO;
      tmp_ff     <= `BYTE_ZERO;
      bus_ff     <= '{addr: START_PC, data: `BYTE_ZERO, rw: 1'b1};
      unknown_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      pc_ff      <= nxt_pc;
      sp_ff      <= nxt_sp;
      x_ff       <= nxt_x;
      y_ff       <= nxt_y;
      acc_a_ff   <= nxt_acc_a;
      acc_b_ff   <= nxt_acc_b;
      flags_ff   <= nxt_flags;
      opcode_ff  <= nxt_opcode;
      prefix_ff  <= nxt_prefix;
      ea_ff      <= nxt_ea;
      tmp_ff     <= nxt_tmp;
      bus_ff     <= nxt_bus;
      unknown_ff <= nxt_unknown;
    end
  end

  assign bus_out             = bus_ff;
  assign acc_a_out           = acc_a_ff;
  assign acc_b_out           = acc_b_ff;
  assign first_pointer_out   = x_ff;
  assign second_pointer_out  = y_ff;
  assign stack_pointer_out   = sp_ff;
  assign program_counter_out = pc_ff;
  assign flag_register_out   = flags_ff;
  assign unknown_opcode_out  = unknown_ff;

endmodule : cpu_exec_core

// ==== design/cpu_exec_regs.svh ====
// opcodes, bus constants and flag bit positions of the execution core
`ifndef CPU_EXEC_REGS_SVH
`define CPU_EXEC_REGS_SVH

`define OP_PREFIX_Y        8'h18
`define OP_BUMP_ACC_A      8'h4c
`define OP_BUMP_ACC_B      8'h5c
`define OP_BUMP_MEM_EXT    8'h7c
`define OP_BUMP_MEM_IDX    8'h6c
`define OP_SP_BUMP         8'h31
`define OP_PTR_BUMP        8'h08
`define OP_JUMP_EXT        8'h7e
`define OP_JUMP_IDX        8'h6e
`define OP_CALL_PAGE       8'h9d
`define OP_CALL_EXT        8'hbd
`define OP_CALL_IDX        8'had
`define OP_LOAD_A_IMM      8'h86
`define OP_LOAD_A_PAGE     8'h96
`define OP_LOAD_A_EXT      8'hb6
`define OP_LOAD_A_IDX      8'ha6
`define OP_LOAD_B_IMM      8'hc6
`define OP_LOAD_B_PAGE     8'hd6
`define OP_LOAD_B_EXT      8'hf6
`define OP_LOAD_B_IDX      8'he6

`define IDLE_ADDR          16'hffff
`define PAGE_ZERO_HI       8'h00
`define OVF_OPERAND        8'h7f
`define BYTE_ZERO          8'h00
`define WORD_ZERO          16'h0000
`define WORD_ONE           16'h0001
`define BYTE_ONE           8'h01

`define FLAG_C             0
`define FLAG_V             1
`define FLAG_Z             2
`define FLAG_N             3

`endif

// ==== design/cpu_exec_pkg.sv ====
// types shared by the execution core and its flag unit
package cpu_exec_pkg;

  typedef enum logic [3:0] {
    st_fetch,
    st_operand1,
    st_operand2,
    st_index_idle,
    st_ea_read,
    st_modify_idle,
    st_ea_write,
    st_stack_read,
    st_pointer_idle,
    st_push_lo,
    st_push_hi
  } exec_state_t;

  typedef enum logic [2:0] {
    cls_bump_acc,
    cls_bump_mem,
    cls_sp_bump,
    cls_ptr_bump,
    cls_jump,
    cls_call,
    cls_load,
    cls_unknown
  } op_class_t;

  typedef enum logic [2:0] {
    md_no_operand,
    md_immediate,
    md_page_zero,
    md_sixteen_bit,
    md_offset_from_pointer
  } addr_mode_t;

  typedef struct packed {
    op_class_t  cls;
    addr_mode_t mode;
    logic       acc_b;
  } decode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rw;
  } bus_t;

  typedef struct packed {
    logic [7:0] value;
    logic       n;
    logic       z;
    logic       v;
  } byte_result_t;

endpackage : cpu_exec_pkg

// ==== design/byte_flag_unit.sv ====
// byte increment or pass-through with negative, zero and overflow flags
`include "cpu_exec_regs.svh"

module byte_flag_unit (
  input  wire logic                        bump_in,
  input  wire logic [7:0]                  operand_in,
  output      cpu_exec_pkg::byte_result_t  result_out
);
  import cpu_exec_pkg::*;

  logic [7:0] value;

  always_comb begin
    value = bump_in ? operand_in + `BYTE_ONE : operand_in;
    result_out.value = value;
    result_out.n = value[7];
    result_out.z = (value == `BYTE_ZERO);
    // a load always clears overflow
    result_out.v = bump_in && (operand_in == `OVF_OPERAND);
  end

endmodule : byte_flag_unit

// ==== verif/exec_props.sv ====
// concurrent checks on the execution core's bus, pointers and flags
`include "cpu_exec_regs.svh"

module exec_props (
  input wire logic                ref_clk_in,
  input wire logic                reset_n_in,
  input wire logic [7:0]          data_in,
  input wire cpu_exec_pkg::bus_t  bus_out,
  input wire logic [15:0]         first_pointer_out,
  input wire logic [15:0]         second_pointer_out,
  input wire logic [15:0]         stack_pointer_out,
  input wire logic [7:0]          flag_register_out
);
  import cpu_exec_pkg::*;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_idle_read: assert property (
    bus_out.addr == `IDLE_ADDR |-> bus_out.rw)
    else $error("idle address cycle is not a read");

  a_push_order: assert property (
    !bus_out.rw ##1 !bus_out.rw |-> bus_out.addr == $past(bus_out.addr) - 16'h0001)
    else $error("second push not one below the first");

  a_push_pair_only: assert property (
    !bus_out.rw ##1 !bus_out.rw |=> bus_out.rw)
    else $error("more than two writes in a row");

  a_push_sp_drop: assert property (
    !bus_out.rw ##1 !bus_out.rw |=> stack_pointer_out == $past(bus_out.addr, 2) - 16'h0002)
    else $error("stack pointer not two below first push");

  // a single write right after an idle cycle can only be a memory bump
  a_mem_writeback: assert property (
    $fell(bus_out.rw) && $past(bus_out.addr) == `IDLE_ADDR
    |-> bus_out.addr == $past(bus_out.addr, 2) && bus_out.data == $past(data_in, 2) + 8'h01)
    else $error("memory bump wrote wrong place or value");

  a_bump_flags: assert property (
    $fell(bus_out.rw) && $past(bus_out.addr) == `IDLE_ADDR
    |-> flag_register_out[`FLAG_V] == (bus_out.data == 8'h80)
        && flag_register_out[`FLAG_N] == bus_out.data[7]
        && flag_register_out[`FLAG_Z] == (bus_out.data == 8'h00))
    else $error("memory bump flags wrong");

  a_carry_kept: assert property (
    $stable(flag_register_out[`FLAG_C]))
    else $error("carry flag changed");

  a_sp_bump_read: assert property (
    stack_pointer_out == $past(stack_pointer_out) + 16'h0001
    |-> $past(bus_out.addr) == $past(stack_pointer_out) && $past(bus_out.rw))
    else $error("stack bump without read at old pointer");

  a_first_ptr_bump: assert property (
    first_pointer_out != $past(first_pointer_out)
    |-> first_pointer_out == $past(first_pointer_out) + 16'h0001
        && $past(bus_out.addr) == `IDLE_ADDR
        && flag_register_out[`FLAG_Z] == (first_pointer_out == 16'h0000))
    else $error("first pointer bump wrong");

  a_second_ptr_bump: assert property (
    second_pointer_out != $past(second_pointer_out)
    |-> second_pointer_out == $past(second_pointer_out) + 16'h0001
        && $past(bus_out.addr) == `IDLE_ADDR
        && flag_register_out[`FLAG_Z] == (second_pointer_out == 16'h0000))
    else $error("second pointer bump wrong");
endmodule : exec_props

// ==== verif/mem_model.sv ====
// memory on the core's bus: zero-wait reads, writes taken at the edge
module mem_model (
  input  wire logic                ref_clk_in,
  input  wire logic                reset_n_in,
  input  wire cpu_exec_pkg::bus_t  bus_in,
  output      logic [7:0]          data_out
);
  import cpu_exec_pkg::*;
  logic [7:0] cells [0:65535];
  logic [7:0] stale_ff;

  initial begin
    for (int i = 0; i < 65536; i++) cells[i] = 8'hc3;
    stale_ff = 8'h5a;
  end

  // write cycles show a toggling byte so nothing stale looks like read data
  assign data_out = bus_in.rw ? cells[bus_in.addr] : stale_ff;

  always @(posedge ref_clk_in) begin
    stale_ff <= ~stale_ff;
    if (reset_n_in && !bus_in.rw) cells[bus_in.addr] <= bus_in.data;
  end
endmodule : mem_model

// ==== verif/tb_top.sv ====
// self-checking bench: program table run through the core and memory model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_exec_pkg::*;

  typedef struct {
    logic [31:0] code;
    int          n;
    int          cyc;
    logic [15:0] nxt;
    int          sel;
    logic [15:0] loc;
    logic [15:0] v;
    logic [7:0]  f;
  } row_t;

  logic        ref_clk_in;
  logic        reset_n_in;
  logic [7:0]  data_in;
  bus_t        bus_out;
  logic [7:0]  acc_a_out;
  logic [7:0]  acc_b_out;
  logic [15:0] first_pointer_out;
  logic [15:0] second_pointer_out;
  logic [15:0] stack_pointer_out;
  logic [15:0] program_counter_out;
  logic [7:0]  flag_register_out;
  logic        unknown_opcode_out;
  int          err_count;
  int          check_count;

  // code, bytes, cycles, next fetch, what to look at (0 a,1 b,2 x,3 y,4 sp,5 mem), where, value,
  // flags; carry starts set and must stay set
  row_t rows [28] = '{
    '{32'h867f0000, 2, 2, 16'h0002, 0, 16'h0, 16'h007f, 8'h01},
    '{32'h4c000000, 1, 2, 16'h0003, 0, 16'h0, 16'h0080, 8'h0b},
    '{32'h5c000000, 1, 2, 16'h0004, 1, 16'h0, 16'h0001, 8'h01},
    '{32'h7c004000, 3, 6, 16'h0007, 5, 16'h0040, 16'h0080, 8'h0b},
    '{32'hc6ff0000, 2, 2, 16'h0009, 1, 16'h0, 16'h00ff, 8'h09},
    '{32'h5c000000, 1, 2, 16'h000a, 1, 16'h0, 16'h0000, 8'h05},
    '{32'h08000000, 1, 3, 16'h000b, 2, 16'h0, 16'h0001, 8'h01},
    '{32'h18080000, 2, 4, 16'h000d, 3, 16'h0, 16'h0001, 8'h01},
    '{32'h31000000, 1, 3, 16'h000e, 4, 16'h0, 16'h0100, 8'h01},
    '{32'h6c3f0000, 2, 6, 16'h0010, 5, 16'h0040, 16'h0081, 8'h09},
    '{32'h186c3f00, 3, 7, 16'h0013, 5, 16'h0040, 16'h0082, 8'h09},
    '{32'hbd020000, 3, 6, 16'h0200, 5, 16'h0100, 16'h0016, 8'h09},
    '{32'h9d800000, 2, 5, 16'h0080, 5, 16'h00fe, 16'h0002, 8'h09},
    '{32'had5f0000, 2, 6, 16'h0060, 5, 16'h00fc, 16'h0082, 8'h09},
    '{32'h18ad6f00, 3, 7, 16'h0070, 4, 16'h0, 16'h00f8, 8'h09},
    '{32'h96500000, 2, 3, 16'h0072, 0, 16'h0, 16'h00ff, 8'h09},
    '{32'h7e040000, 3, 3, 16'h0400, 0, 16'h0, 16'h00ff, 8'h09},
    '{32'h6e200000, 2, 3, 16'h0021, 2, 16'h0, 16'h0001, 8'h09},
    '{32'h186e3000, 3, 4, 16'h0031, 3, 16'h0, 16'h0001, 8'h09},
    '{32'h4c000000, 1, 2, 16'h0032, 0, 16'h0, 16'h0000, 8'h05},
    '{32'hb6004000, 3, 4, 16'h0035, 0, 16'h0, 16'h0082, 8'h09},
    '{32'he63f0000, 2, 4, 16'h0037, 1, 16'h0, 16'h0082, 8'h09},
    '{32'h18a64f00, 3, 5, 16'h003a, 0, 16'h0, 16'h00ff, 8'h09},
    '{32'hd6500000, 2, 3, 16'h003c, 1, 16'h0, 16'h00ff, 8'h09},
    '{32'h7e050000, 3, 3, 16'h0500, 2, 16'h0, 16'h0001, 8'h09},
    '{32'hf6004000, 3, 4, 16'h0503, 1, 16'h0, 16'h0082, 8'h09},
    '{32'ha63f0000, 2, 4, 16'h0505, 0, 16'h0, 16'h0082, 8'h09},
    '{32'h18e64f00, 3, 5, 16'h0508, 1, 16'h0, 16'h00ff, 8'h09}
  };

  cpu_exec_core #(.START_FLAGS(8'h01)) dut (
    .ref_clk_in          (ref_clk_in),
    .reset_n_in          (reset_n_in),
    .data_in             (data_in),
    .bus_out             (bus_out),
    .acc_a_out           (acc_a_out),
    .acc_b_out           (acc_b_out),
    .first_pointer_out   (first_pointer_out),
    .second_pointer_out  (second_pointer_out),
    .stack_pointer_out   (stack_pointer_out),
    .program_counter_out (program_counter_out),
    .flag_register_out   (flag_register_out),
    .unknown_opcode_out  (unknown_opcode_out)
  );

  mem_model mem (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .bus_in     (bus_out),
    .data_out   (data_in)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  function automatic logic [15:0] pick(input row_t r);
    case (r.sel)
      0:       pick = {8'h00, acc_a_out};
      1:       pick = {8'h00, acc_b_out};
      2:       pick = first_pointer_out;
      3:       pick = second_pointer_out;
      4:       pick = stack_pointer_out;
      default: pick = {8'h00, mem.cells[r.loc]};
    endcase
  endfunction : pick

  task automatic run_row(input row_t r);
    repeat (r.cyc) @(posedge ref_clk_in);
    #2;
    chk("fetch address", r.nxt, bus_out.addr);
    chk("fetch rw", 16'h0001, {15'h0000, bus_out.rw});
    chk("program counter", r.nxt, program_counter_out);
    chk("no unknown", 16'h0000, {15'h0000, unknown_opcode_out});
    chk("result", r.v, pick(r));
    chk("flags", {8'h00, r.f}, {8'h00, flag_register_out});
  endtask : run_row

  task automatic check_reset();
    chk("reset fetch", 16'h0000, bus_out.addr);
    chk("reset pc", 16'h0000, program_counter_out);
    chk("reset unknown", 16'h0000, {15'h0000, unknown_opcode_out});
    chk("reset stack", 16'h00ff, stack_pointer_out);
    chk("reset flags", 16'h0001, {8'h00, flag_register_out});
    chk("reset accs", 16'h0000, {acc_a_out, acc_b_out});
  endtask : check_reset

  task final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial begin
    int a;
    reset_n_in  = 1'b0;
    err_count   = 0;
    check_count = 0;
    a           = 0;
    #1;
    mem.cells[16'h0040] = 8'h7f;
    mem.cells[16'h0050] = 8'hff;
    foreach (rows[i]) begin
      for (int k = 0; k < rows[i].n; k++) mem.cells[a + k] = rows[i].code[31 - 8 * k -: 8];
      a = rows[i].nxt;
    end
    // undecoded opcode, then a doubled prefix, right after the table
    mem.cells[16'h0508] = 8'h01;
    mem.cells[16'h0509] = 8'h18;
    mem.cells[16'h050a] = 8'h18;
    repeat (20) @(posedge ref_clk_in);
    #2;
    check_reset();
    reset_n_in = 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    // undecoded opcode is a two-cycle no-op, doubled prefix a three-cycle one: dummy read not skipped, pulse stands one cycle
    repeat (2) @(posedge ref_clk_in);
    #2;
    chk("unknown dummy addr", 16'h0509, bus_out.addr);
    chk("unknown pulse", 16'h0001, {15'h0000, unknown_opcode_out});
    @(posedge ref_clk_in);
    #2;
    chk("unknown pulse end", 16'h0000, {15'h0000, unknown_opcode_out});
    repeat (2) @(posedge ref_clk_in);
    #2;
    chk("double prefix", 16'h0001, {15'h0000, unknown_opcode_out});
    chk("double prefix addr", 16'h050b, bus_out.addr);
    chk("unknown flags", 16'h0009, {8'h00, flag_register_out});
    // reset again mid-run; the core must restart from the start address
    reset_n_in = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #2;
    check_reset();
    reset_n_in = 1'b1;
    run_row(rows[0]);
    final_report();
  end

  initial begin
    repeat (2000) @(posedge ref_clk_in);
    err_count++;
    $display("ERROR watchdog expected finish seen timeout");
    final_report();
  end
endmodule : tb_top

bind cpu_exec_core exec_props chk_i (
  .ref_clk_in         (ref_clk_in),
  .reset_n_in         (reset_n_in),
  .data_in            (data_in),
  .bus_out            (bus_out),
  .first_pointer_out  (first_pointer_out),
  .second_pointer_out (second_pointer_out),
  .stack_pointer_out  (stack_pointer_out),
  .flag_register_out  (flag_register_out)
);
